// ==== hw/channel_quality_monitor.sv ====
// Channel quality monitor top: filtering, windows, capture and results
`timescale 1ns/10ps

// How it works
// [RL1] Map symbols to references +-128, +-64, 0
// [RL2] Slice at +-64, or +-32 and +-96
// [RL3] Error magnitude up to 64 or 32
// [RL4] Measurements run only while enabled
// [RL5] Filter absolute error, doubled at gigabit
// [RL6] Square mode squares the scaled error
// [RL7] Mean filter weight is one over two to the shift
// [RL8] MSE is snapshot scaled down, capped 511
// [RL9] Capture bit self-clears, loads selected pair
// [RL10] Snapshot filtered error every 125000 symbols
// [RL11] Keep worst MSE since last read
// [RL12] Index from threshold table, 7 best
// [RL13] Capture gives index and lowest since read
// [RL14] Link loss only when index is zero
// [RL15] Capture delivers the filtered mean error
// [RL16] Peak filter, window maximum each window
// [RL17] Peak scaled by shift plus three, cap 63
// [RL18] Peak result holds current and worst
// [RL19] Reading a result restarts worst tracking
module channel_quality_monitor
#(
    parameter int WINDOW_SYMBOLS = cq_pkg::WINDOW_SYMBOLS
)
(
    input  wire logic                        sys_clk,
    input  wire logic                        reset,
    input  wire cq_pkg::cfg_t                cfg,
    input  wire cq_pkg::symbol_t             rx,
    input  wire cq_pkg::threshold_table_t    quality_threshold,
    input  wire logic                        capture_write,
    input  wire logic [1:0]                  capture_channel,
    input  wire logic                        mse_read,
    input  wire logic                        index_read,
    input  wire logic                        peak_read,
    output logic                             read_capture,
    output cq_pkg::result_t                  result,
    output logic                             link_loss
);

    // ****************************************************************
    // Declarations
    // ****************************************************************
    logic                           tick;
    logic                           window_end;
    logic                           accept;
    logic [cq_pkg::WIN_W-1:0]       win_count;
    logic [cq_pkg::WIN_W-1:0]       next_win_count;
    logic [cq_pkg::VALUE_W-1:0]     error_value [cq_pkg::PAIRS];
    logic [cq_pkg::VALUE_W-1:0]     mean_value [cq_pkg::PAIRS];
    logic [cq_pkg::VALUE_W-1:0]     peak_value [cq_pkg::PAIRS];
    logic [cq_pkg::VALUE_W-1:0]     mean_snap [cq_pkg::PAIRS];
    logic [cq_pkg::VALUE_W-1:0]     next_mean_snap [cq_pkg::PAIRS];
    logic [cq_pkg::VALUE_W-1:0]     peak_snap [cq_pkg::PAIRS];
    logic [cq_pkg::VALUE_W-1:0]     next_peak_snap [cq_pkg::PAIRS];
    logic [cq_pkg::VALUE_W-1:0]     peak_run [cq_pkg::PAIRS];
    logic [cq_pkg::VALUE_W-1:0]     next_peak_run [cq_pkg::PAIRS];
    logic [cq_pkg::VALUE_W-1:0]     sel_mean;
    logic [cq_pkg::VALUE_W-1:0]     sel_peak_raw;
    logic [cq_pkg::VALUE_W-1:0]     mse_shifted;
    logic [cq_pkg::VALUE_W-1:0]     peak_shifted;
    logic [cq_pkg::SHIFT_W:0]       peak_amount;
    logic [cq_pkg::MSE_W-1:0]       sel_mse;
    logic [cq_pkg::PEAK_W-1:0]      sel_peak;
    logic [cq_pkg::INDEX_W-1:0]     sel_index;
    cq_pkg::result_t                next_result;
    logic                           next_read_capture;
    logic                           next_link_loss;
    logic                           mse_restart;
    logic                           next_mse_restart;
    logic                           index_restart;
    logic                           next_index_restart;
    logic                           peak_restart;
    logic                           next_peak_restart;

    assign tick       = rx.valid && cfg.enable;                         // [RL4]
    assign window_end = tick && win_count == cq_pkg::WIN_W'(WINDOW_SYMBOLS - 1); // [RL10]
    assign accept     = capture_write && cfg.enable;                    // [RL4]

    // ****************************************************************
    // Per-pair slicer and filters
    // ****************************************************************
    for (genvar p = 0; p < cq_pkg::PAIRS; p++)
    begin : g_pair
        slicer_error u_slicer
        (
            .level       (rx.level[p]),
            .gigabit     (cfg.gigabit),
            .square_mode (cfg.square_mode),
            .value       (error_value[p])
        );

        error_filter u_mean
        (
            .sys_clk (sys_clk),
            .reset   (reset),
            .update  (tick),
            .shift   (cfg.mean_filter_shift),                           // [RL7]
            .sample  (error_value[p]),
            .value   (mean_value[p])
        );

        error_filter u_peak
        (
            .sys_clk (sys_clk),
            .reset   (reset),
            .update  (tick),
            .shift   (cfg.peak_filter_shift),                           // [RL16]
            .sample  (error_value[p]),
            .value   (peak_value[p])
        );
    end

    // ****************************************************************
    // Window counter, snapshots and running peak
    // ****************************************************************
    always_comb
    begin
        next_win_count = win_count;
        next_mean_snap = mean_snap;
        next_peak_snap = peak_snap;
        next_peak_run  = peak_run;
        if (window_end)
        begin
            next_win_count = '0;
            for (int p = 0; p < cq_pkg::PAIRS; p++)
            begin
                next_mean_snap[p] = mean_value[p];                      // [RL10]
                next_peak_snap[p] = (peak_value[p] > peak_run[p]) ? peak_value[p]
                                                                  : peak_run[p]; // [RL16]
                next_peak_run[p]  = '0;
            end
        end
        else if (tick)
        begin
            next_win_count = cq_pkg::WIN_W'(win_count + 1'b1);
            for (int p = 0; p < cq_pkg::PAIRS; p++)
            begin
                if (peak_value[p] > peak_run[p])
                    next_peak_run[p] = peak_value[p];                   // [RL16]
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            win_count <= '0;
            for (int p = 0; p < cq_pkg::PAIRS; p++)
            begin
                mean_snap[p] <= '0;
                peak_snap[p] <= '0;
                peak_run[p]  <= '0;
            end
        end
        else
        begin
            win_count <= next_win_count;
            mean_snap <= next_mean_snap;
            peak_snap <= next_peak_snap;
            peak_run  <= next_peak_run;
        end
    end

    // ****************************************************************
    // Selected pair: scaling and quality index
    // ****************************************************************
    always_comb
    begin
        sel_mean     = mean_snap[capture_channel];
        sel_peak_raw = peak_snap[capture_channel];
        mse_shifted  = sel_mean >> cfg.mean_scale_shift;                // [RL8]
        sel_mse      = (|mse_shifted[cq_pkg::VALUE_W-1:cq_pkg::MSE_W]) ? cq_pkg::MSE_MAX
                       : mse_shifted[cq_pkg::MSE_W-1:0];                // [RL8]
        peak_amount  = {1'b0, cfg.peak_scale_shift} + cq_pkg::PEAK_SCALE_BIAS; // [RL17]
        peak_shifted = sel_peak_raw >> peak_amount;
        sel_peak     = (|peak_shifted[cq_pkg::VALUE_W-1:cq_pkg::PEAK_W]) ? cq_pkg::PEAK_MAX
                       : peak_shifted[cq_pkg::PEAK_W-1:0];              // [RL17]
        sel_index    = cq_pkg::INDEX_WORST;
        for (int n = 1; n <= 7; n++)
        begin
            if (sel_mse <= quality_threshold[n])
                sel_index = cq_pkg::INDEX_W'(n);                        // [RL12]
        end
    end

    // ****************************************************************
    // Capture, worst-case tracking and results
    // ****************************************************************
    always_comb
    begin
        next_result        = result;
        next_read_capture  = capture_write;                             // [RL9]
        next_link_loss     = link_loss;
        next_mse_restart   = mse_read   ? 1'b1 : (accept ? 1'b0 : mse_restart);   // [RL19]
        next_index_restart = index_read ? 1'b1 : (accept ? 1'b0 : index_restart); // [RL19]
        next_peak_restart  = peak_read  ? 1'b1 : (accept ? 1'b0 : peak_restart);  // [RL19]
        if (accept)
        begin
            next_result.mse        = sel_mse;                           // [RL9]
            next_result.mse_worst  = (mse_restart || sel_mse > result.mse_worst)
                                     ? sel_mse : result.mse_worst;      // [RL11]
            next_result.index      = sel_index;                         // [RL13]
            next_result.index_worst = (index_restart || sel_index < result.index_worst)
                                     ? sel_index : result.index_worst;  // [RL13]
            next_result.mean_error = sel_mean;                          // [RL15]
            next_result.peak       = sel_peak;                          // [RL18]
            next_result.peak_worst = (peak_restart || sel_peak > result.peak_worst)
                                     ? sel_peak : result.peak_worst;    // [RL18]
            next_link_loss         = sel_index == cq_pkg::INDEX_WORST;  // [RL14]
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            result        <= '0;
            read_capture  <= 1'b0;
            link_loss     <= 1'b0;
            mse_restart   <= 1'b1;
            index_restart <= 1'b1;
            peak_restart  <= 1'b1;
        end
        else
        begin
            result        <= next_result;
            read_capture  <= next_read_capture;
            link_loss     <= next_link_loss;
            mse_restart   <= next_mse_restart;
            index_restart <= next_index_restart;
            peak_restart  <= next_peak_restart;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_capture_self_clear: // [RL9]
        assert property (@(posedge sys_clk) disable iff (reset)
            capture_write |=> read_capture ##1 !read_capture || $past(capture_write))
        else $error("Capture bit did not self-clear");

    a_mean_error_load: // [RL15]
        assert property (@(posedge sys_clk) disable iff (reset)
            accept |=> result.mean_error == $past(sel_mean))
        else $error("Mean error result not loaded from selected pair");

    a_mse_saturate: // [RL8]
        assert property (@(posedge sys_clk) disable iff (reset)
            accept && (sel_mean >> cfg.mean_scale_shift) > 13'h01FF |=> result.mse == 9'h1FF)
        else $error("MSE did not saturate at 511");

    a_peak_saturate: // [RL17]
        assert property (@(posedge sys_clk) disable iff (reset)
            accept && (sel_peak_raw >> (cfg.peak_scale_shift + 5'h03)) > 13'h003F
            |=> result.peak == 6'h3F)
        else $error("Peak did not saturate at 63");

    a_index_best: // [RL12]
        assert property (@(posedge sys_clk) disable iff (reset)
            accept && sel_mse <= quality_threshold[7] |=> result.index == 3'h7)
        else $error("Index not 7 at or below threshold seven");

    a_index_zero: // [RL12]
        assert property (@(posedge sys_clk) disable iff (reset)
            accept && sel_mse > quality_threshold[1] |=> result.index == 3'h0)
        else $error("Index not 0 above threshold one");

    a_window_wrap: // [RL10]
        assert property (@(posedge sys_clk) disable iff (reset)
            window_end |=> win_count == 17'h00000 && mean_snap[0] == $past(mean_value[0]))
        else $error("Window end did not snapshot and restart");

    a_disable_freeze: // [RL4]
        assert property (@(posedge sys_clk) disable iff (reset)
            !cfg.enable |=> $stable(win_count) && $stable(mean_snap[0]))
        else $error("Measurement moved while disabled");

    a_worst_mse: // [RL11]
        assert property (@(posedge sys_clk) disable iff (reset)
            accept |=> result.mse_worst >= result.mse)
        else $error("Worst MSE below current MSE");

    a_restart_read: // [RL19]
        assert property (@(posedge sys_clk) disable iff (reset)
            mse_read ##1 accept |=> result.mse_worst == result.mse)
        else $error("Worst MSE not restarted after read");

    a_peak_window: // [RL16]
        assert property (@(posedge sys_clk) disable iff (reset)
            window_end |=> peak_snap[0] >= $past(peak_value[0]) && peak_run[0] == 13'h0000)
        else $error("Window peak not stored");

    a_link_loss: // [RL14]
        assert property (@(posedge sys_clk) disable iff (reset)
            link_loss |-> result.index == 3'h0)
        else $error("Link loss with nonzero index");

endmodule

// ==== hw/cq_pkg.sv ====
// Shared constants and carrier types of the channel quality monitor
package cq_pkg;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int PAIRS   = 4;
    localparam int LEVEL_W = 9;
    localparam int ERR_W   = 7;
    localparam int VALUE_W = 13;
    localparam int FRAC_W  = 15;
    localparam int ACC_W   = VALUE_W + FRAC_W;
    localparam int SHIFT_W = 4;
    localparam int MSE_W   = 9;
    localparam int PEAK_W  = 6;
    localparam int INDEX_W = 3;
    localparam int WIN_W   = 17;

    // ****************************************************************
    // Slicer levels, thresholds and limits
    // ****************************************************************
    localparam logic signed [LEVEL_W-1:0] REF_OUTER     = 9'sh080;
    localparam logic signed [LEVEL_W-1:0] REF_INNER     = 9'sh040;
    localparam logic signed [LEVEL_W-1:0] THR_FAST      = 9'sh040;
    localparam logic signed [LEVEL_W-1:0] THR_GIG_OUTER = 9'sh060;
    localparam logic signed [LEVEL_W-1:0] THR_GIG_INNER = 9'sh020;
    localparam logic [ERR_W-1:0]          MAX_ERR_FAST  = 7'h40;
    localparam logic [ERR_W-1:0]          MAX_ERR_GIG   = 7'h20;
    localparam logic [MSE_W-1:0]          MSE_MAX       = 9'h1FF;
    localparam logic [PEAK_W-1:0]         PEAK_MAX      = 6'h3F;
    localparam logic [SHIFT_W:0]          PEAK_SCALE_BIAS = 5'h03;
    localparam logic [INDEX_W-1:0]        INDEX_BEST    = 3'h7;
    localparam logic [INDEX_W-1:0]        INDEX_WORST   = 3'h0;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int WINDOW_TIME_US     = 1000;
    localparam int SYMBOLS_PER_US     = 125;
    localparam int WINDOW_SYMBOLS     = WINDOW_TIME_US * SYMBOLS_PER_US;

    // ****************************************************************
    // Carrier types
    // ****************************************************************
    typedef logic signed [LEVEL_W-1:0] level_t;

    typedef struct packed {
        logic                      valid;
        level_t [PAIRS-1:0]        level;
    } symbol_t;

    typedef struct packed {
        logic                      enable;
        logic                      square_mode;
        logic                      gigabit;
        logic [SHIFT_W-1:0]        mean_filter_shift;
        logic [SHIFT_W-1:0]        peak_filter_shift;
        logic [SHIFT_W-1:0]        mean_scale_shift;
        logic [SHIFT_W-1:0]        peak_scale_shift;
    } cfg_t;

    typedef logic [7:1][MSE_W-1:0] threshold_table_t;

    typedef struct packed {
        logic [MSE_W-1:0]          mse;
        logic [MSE_W-1:0]          mse_worst;
        logic [INDEX_W-1:0]        index;
        logic [INDEX_W-1:0]        index_worst;
        logic [VALUE_W-1:0]        mean_error;
        logic [PEAK_W-1:0]         peak;
        logic [PEAK_W-1:0]         peak_worst;
    } result_t;

endpackage

// ==== hw/slicer_error.sv ====
// Slicer error of one pair, scaled and optionally squared
`timescale 1ns/10ps

module slicer_error
(
    input  wire cq_pkg::level_t              level,
    input  wire logic                        gigabit,
    input  wire logic                        square_mode,
    output logic [cq_pkg::VALUE_W-1:0]       value
);

    // ****************************************************************
    // Nearest reference and error magnitude
    // ****************************************************************
    always_comb
    begin
        logic signed [cq_pkg::LEVEL_W-1:0] ref_level;
        logic signed [cq_pkg::LEVEL_W:0]   diff;
        logic [cq_pkg::LEVEL_W:0]          mag;
        logic [cq_pkg::ERR_W-1:0]          err;
        logic [cq_pkg::ERR_W:0]            scaled;
        logic [cq_pkg::VALUE_W-1:0]        wide;
        ref_level = '0;
        diff      = '0;
        mag       = '0;
        err       = '0;
        scaled    = '0;
        wide      = '0;
        if (gigabit)
        begin
            if (level > cq_pkg::THR_GIG_OUTER)                   // [RL2]
                ref_level = cq_pkg::REF_OUTER;                   // [RL1]
            else if (level > cq_pkg::THR_GIG_INNER)
                ref_level = cq_pkg::REF_INNER;
            else if (level >= -cq_pkg::THR_GIG_INNER)
                ref_level = '0;
            else if (level >= -cq_pkg::THR_GIG_OUTER)
                ref_level = -cq_pkg::REF_INNER;
            else
                ref_level = -cq_pkg::REF_OUTER;
        end
        else
        begin
            if (level > cq_pkg::THR_FAST)                        // [RL2]
                ref_level = cq_pkg::REF_OUTER;                   // [RL1]
            else if (level >= -cq_pkg::THR_FAST)
                ref_level = '0;
            else
                ref_level = -cq_pkg::REF_OUTER;
        end
        diff = {level[cq_pkg::LEVEL_W-1], level} - {ref_level[cq_pkg::LEVEL_W-1], ref_level};
        mag  = diff[cq_pkg::LEVEL_W] ? (cq_pkg::LEVEL_W+1)'(-diff) : diff;
        // Outer levels clamp to the largest error magnitude
        if (gigabit)
            err = (mag > 10'(cq_pkg::MAX_ERR_GIG)) ? cq_pkg::MAX_ERR_GIG
                                                   : mag[cq_pkg::ERR_W-1:0]; // [RL3]
        else
            err = (mag > 10'(cq_pkg::MAX_ERR_FAST)) ? cq_pkg::MAX_ERR_FAST
                                                    : mag[cq_pkg::ERR_W-1:0]; // [RL3]
        scaled = gigabit ? {err, 1'b0} : {1'b0, err};                // [RL5]
        wide   = {5'h00, scaled};
        value  = square_mode ? cq_pkg::VALUE_W'(wide * wide) : wide; // [RL6]
    end

endmodule

// ==== hw/error_filter.sv ====
// First-order low-pass filter of one error stream
`timescale 1ns/10ps

module error_filter
(
    input  wire logic                        sys_clk,
    input  wire logic                        reset,
    input  wire logic                        update,
    input  wire logic [cq_pkg::SHIFT_W-1:0]  shift,
    input  wire logic [cq_pkg::VALUE_W-1:0]  sample,
    output logic [cq_pkg::VALUE_W-1:0]       value
);

    logic [cq_pkg::ACC_W-1:0]   acc;
    logic [cq_pkg::ACC_W-1:0]   next_acc;

    // ****************************************************************
    // Weighted add-back of the difference
    // ****************************************************************
    always_comb
    begin
        logic signed [cq_pkg::ACC_W:0] delta;
        logic signed [cq_pkg::ACC_W:0] sum;
        delta    = $signed({1'b0, sample, {cq_pkg::FRAC_W{1'b0}}}) - $signed({1'b0, acc}); // [RL5]
        sum      = $signed({1'b0, acc}) + (delta >>> shift); // [RL7]
        next_acc = acc;
        if (update)
            next_acc = sum[cq_pkg::ACC_W-1:0];               // [RL4]
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            acc <= '0;
        else
            acc <= next_acc;
    end

    assign value = acc[cq_pkg::ACC_W-1:cq_pkg::FRAC_W];

    a_filter_hold: // [RL4]
        assert property (@(posedge sys_clk) disable iff (reset) !update |=> $stable(acc))
        else $error("Filter moved without an update");

    a_filter_unity: // [RL7]
        assert property (@(posedge sys_clk) disable iff (reset)
            update && shift == 4'h0 |=> value == $past(sample))
        else $error("Unity weight did not load the sample");

endmodule

// ==== dv/symbol_source.sv ====
// Receive slicer stand-in sending bursts of symbols
`timescale 1ns/10ps

module symbol_source
(
    input  wire logic                 sys_clk,
    input  wire logic                 reset,
    input  wire logic                 start,
    input  wire cq_pkg::level_t [3:0] level,
    output cq_pkg::symbol_t           rx,
    output logic                      busy
);
    int left;

    assign busy = (left != 0) || rx.valid;

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            left <= 0;
            rx   <= '0;
        end
        else
        begin
            if (start)
                left <= 32;
            else if (left != 0)
                left <= left - 1;
            rx.valid <= (left != 0);
            rx.level <= (left != 0) ? level : ~rx.level;
        end
    end
endmodule

// ==== dv/tb_top.sv ====
// Self-checking bench of the channel quality monitor
`timescale 1ns/10ps

module tb_top;
    typedef struct packed {
        logic           gig;
        logic           sq;
        cq_pkg::level_t lvl;
        logic [3:0]     scale;
        logic [8:0]     mse;
        logic [2:0]     idx;
        logic [12:0]    err;
        logic [5:0]     pk;
    } row_t;
    logic                     sys_clk, reset, start, busy, capture_write;
    logic                     mse_read, index_read, peak_read, read_capture, link_loss;
    logic [1:0]               capture_channel;
    cq_pkg::cfg_t             cfg;
    cq_pkg::symbol_t          rx;
    cq_pkg::threshold_table_t quality_threshold;
    cq_pkg::level_t [3:0]     level;
    cq_pkg::result_t          result;
    int                       n_mismatch = 0;
    int                       checked = 0;
    row_t                     fin = {2'h0, 9'h00A, 4'h0, 9'h00A, 3'h7, 13'h000A, 6'h01};
    row_t                     rows [6] = '{
        {2'h0, 9'h014, 4'h0, 9'h014, 3'h6, 13'h0014, 6'h02},
        {2'h1, 9'h1E2, 4'h1, 9'h1C2, 3'h1, 13'h0384, 6'h3F},
        {2'h3, 9'h046, 4'h0, 9'h090, 3'h3, 13'h0090, 6'h12},
        {2'h3, 9'h064, 4'h0, 9'h1FF, 3'h0, 13'h0C40, 6'h3F},
        {2'h0, 9'h040, 4'h0, 9'h040, 3'h5, 13'h0040, 6'h08},
        {2'h2, 9'h1E0, 4'h0, 9'h040, 3'h5, 13'h0040, 6'h08}};

    channel_quality_monitor #(.WINDOW_SYMBOLS(16)) DUT
    (
        .sys_clk           (sys_clk),
        .reset             (reset),
        .cfg               (cfg),
        .rx                (rx),
        .quality_threshold (quality_threshold),
        .capture_write     (capture_write),
        .capture_channel   (capture_channel),
        .mse_read          (mse_read),
        .index_read        (index_read),
        .peak_read         (peak_read),
        .read_capture      (read_capture),
        .result            (result),
        .link_loss         (link_loss)
    );

    symbol_source src
    (
        .sys_clk (sys_clk),
        .reset   (reset),
        .start   (start),
        .level   (level),
        .rx      (rx),
        .busy    (busy)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(string name, logic [12:0] exp, logic [12:0] got);
        checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    task automatic burst();
        int n = 0;
        start <= 1'b1;
        @(posedge sys_clk);
        start <= 1'b0;
        #1;
        while (busy !== 1'b0 && n < 100)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        if (n == 100)
        begin
            n_mismatch++;
            end_of_test();
        end
    endtask

    task automatic capture(logic [1:0] ch, logic rd);
        mse_read   <= rd;
        index_read <= rd;
        peak_read  <= rd;
        @(posedge sys_clk);
        mse_read        <= 1'b0;
        index_read      <= 1'b0;
        peak_read       <= 1'b0;
        capture_write   <= 1'b1;
        capture_channel <= ch;
        @(posedge sys_clk);
        capture_write <= 1'b0;
        #1;
        chk("read_capture", 13'h0001, 13'(read_capture));
        @(posedge sys_clk);
        #1;
        chk("read_capture", 13'h0000, 13'(read_capture));
    endtask

    task automatic check_result(row_t r, logic [8:0] mw, logic [2:0] iw, logic [5:0] pw);
        chk("mse", 13'(r.mse), 13'(result.mse));
        chk("mse_worst", 13'(mw), 13'(result.mse_worst));
        chk("index", 13'(r.idx), 13'(result.index));
        chk("index_worst", 13'(iw), 13'(result.index_worst));
        chk("mean_error", r.err, result.mean_error);
        chk("peak", 13'(r.pk), 13'(result.peak));
        chk("peak_worst", 13'(pw), 13'(result.peak_worst));
        chk("link_loss", 13'(r.idx == 3'h0), 13'(link_loss));
    endtask

    initial
    begin
        reset = 1'b1;
        start = 1'b0;
        capture_write = 1'b0;
        capture_channel = 2'h0;
        mse_read = 1'b0;
        index_read = 1'b0;
        peak_read = 1'b0;
        cfg = '0;
        level = '0;
        quality_threshold = {9'h010, 9'h020, 9'h040, 9'h080, 9'h100, 9'h190, 9'h1F4};
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk("reset", 13'h0000, 13'({|result, link_loss, read_capture}));
        $display("test reset done");
        for (int i = 0; i < 6; i++)
        begin
            cfg   <= {1'b1, rows[i].sq, rows[i].gig, 8'h00, rows[i].scale, 4'h0};
            level <= {27'h0000000, rows[i].lvl} << (9 * (i % 4));
            burst();
            capture(2'(i % 4), 1'b1);
            check_result(rows[i], rows[i].mse, rows[i].idx, rows[i].pk);
            $display("test row %0d done", i);
        end
        // Worst values kept without a read
        cfg   <= 19'h40000;
        level <= {27'h0000000, 9'h00A};
        burst();
        capture(2'h0, 1'b0);
        check_result(fin, 9'h040, 3'h5, 6'h08);
        $display("test worst done");
        // Symbols ignored while disabled
        cfg   <= 19'h00000;
        level <= {27'h0000000, 9'h064};
        burst();
        capture(2'h0, 1'b0);
        check_result(fin, 9'h040, 3'h5, 6'h08);
        $display("test disabled done");
        // Mean weight of one half settles one below the sample
        cfg   <= 19'h41000;
        level <= {27'h0000000, 9'h014};
        burst();
        capture(2'h0, 1'b0);
        fin = {2'h0, 9'h014, 4'h0, 9'h013, 3'h6, 13'h0013, 6'h02};
        check_result(fin, 9'h040, 3'h5, 6'h08);
        $display("test weight done");
        end_of_test();
    end
endmodule
